//--- core/cpr_bank.sv
// register bank: file registers, status, option, counter, port controls
// assumes the core drives one request struct per cycle, inputs synchronous
`timescale 1ns/1ps
module cpr_bank (
	input  wire logic                 core_clk,
	input  wire logic                 nrst,
	input  wire cpr_pkg::cpr_req_t    req,
	input  wire cpr_pkg::cpr_evt_t    evt,
	input  wire logic [4:0][7:0]      pin_in,
	input  wire logic                 cmp_gt,
	input  wire logic                 counter_pin,
	input  wire logic                 carry_input_fuse,
	output logic                      rd_valid_q,
	output logic [7:0]                rd_data_q,
	output logic [7:0]                w_q,
	output logic [4:0]                mode_q,
	output logic [7:0]                status_q,
	output logic [7:0]                option_q,
	output logic [7:0]                fsel_q,
	output logic [7:0]                counter_q,
	output logic [7:0]                pc_low_q,
	output logic                      branch_q,
	output logic [11:0]               branch_addr_q,
	output logic [7:0]                alu_result_q,
	output logic [4:0][7:0]           port_data_q,
	output logic [4:0][7:0]           dir_q,
	output logic [4:0][7:0]           pullup_q,
	output logic [4:0][7:0]           level_q,
	output logic [4:0][7:0]           hysteresis_q,
	output logic [7:0]                wake_pin_enable_q,
	output logic [7:0]                wake_edge_select_q,
	output logic [7:0]                wake_pending_q,
	output logic                      wake_event_q,
	output logic [7:0]                comparator_reg_q,
	output logic                      rollover_irq_q,
	output logic                      wdt_scaled_q
);
	import cpr_pkg::*;

	logic [7:0]  ram_q [ADDR_RAM_FIRST:ADDR_RAM_LAST];
	logic [4:0]  eff_addr;
	logic        fwr;
	logic [7:0]  frd;
	logic [3:0]  mlo;
	logic        mwr;
	logic        port_ok;
	logic        is_b;
	logic        x_cmp;
	logic        x_pend;
	logic        wr_wedge;
	logic        wr_wen;
	logic        rd_cfg;
	logic [7:0]  pctl_rdata;
	logic [7:0]  b_eff;
	logic        cin;
	logic [8:0]  sum9;
	logic [4:0]  nib5;
	logic [7:0]  alu_res;
	logic        alu_cout;
	logic        alu_dcout;
	logic        prev_cpin_q;
	logic        src_tick;
	logic        ps_tick;
	logic [3:0]  shift;
	logic [8:0]  mask9;
	logic [7:0]  ps_cnt_q;
	logic        ps_hit;
	logic        cnt_inc;
	logic [7:0]  prev_b_q;
	logic [7:0]  wake_set;

	// indirect through file select; 00h itself stores nothing
	always_comb begin
		eff_addr = req.file_addr;
		if (req.file_addr == ADDR_INDIRECT) begin
			eff_addr = fsel_q[4:0];
		end
	end
	assign fwr = req.file_wr && (eff_addr != ADDR_INDIRECT);

	always_comb begin
		frd = ZERO_BYTE;
		if (eff_addr == ADDR_COUNTER) begin
			frd = option_q[OPT_MAP] ? counter_q : w_q;
		end else if (eff_addr == ADDR_PC_LOW) begin
			frd = pc_low_q;
		end else if (eff_addr == ADDR_STATUS) begin
			frd = status_q;
		end else if (eff_addr == ADDR_FSEL) begin
			frd = fsel_q;
		end else if (eff_addr >= ADDR_PORT_A && eff_addr <= ADDR_PORT_E) begin
			frd = pin_in[3'(eff_addr - ADDR_PORT_A)];
		end else if (eff_addr >= ADDR_RAM_FIRST) begin
			frd = ram_q[eff_addr];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= ZERO_BYTE;
		end else begin
			rd_valid_q <= req.file_rd;
			rd_data_q  <= req.file_rd ? frd : ZERO_BYTE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (fwr && eff_addr >= ADDR_RAM_FIRST) begin
			ram_q[eff_addr] <= req.file_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fsel_q <= ZERO_BYTE;
		end else if (fwr && eff_addr == ADDR_FSEL) begin
			fsel_q <= req.file_wdata;
		end
	end

	// mode register; stays until written again
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mode_q <= MODE_RESET;
		end else if (req.mode_wr) begin
			mode_q <= req.mode_wdata;
		end
	end

	// port-control access decode
	assign mlo      = mode_q[3:0];
	assign mwr      = mode_q[MODE_WRITE_BIT];
	assign port_ok  = req.pctl && (req.pctl_port <= PORT_E);
	assign is_b     = port_ok && (req.pctl_port == PORT_B);
	assign x_cmp    = is_b && (mlo == MODE_CMP);
	assign x_pend   = is_b && (mlo == MODE_PEND);
	assign wr_wedge = is_b && (mlo == MODE_WEDGE);
	assign wr_wen   = is_b && (mlo == MODE_WEN);
	assign rd_cfg   = port_ok && !mwr && (mlo >= MODE_SCHMITT);

	always_comb begin
		pctl_rdata = ZERO_BYTE;
		if (port_ok) begin
			case (mlo)
				MODE_CMP: begin
					pctl_rdata = is_b ? comparator_reg_q : ZERO_BYTE;
				end
				MODE_PEND: begin
					pctl_rdata = is_b ? wake_pending_q : ZERO_BYTE;
				end
				MODE_SCHMITT: begin
					pctl_rdata = hysteresis_q[req.pctl_port];
				end
				MODE_LEVEL: begin
					pctl_rdata = level_q[req.pctl_port];
				end
				MODE_PULLUP: begin
					pctl_rdata = pullup_q[req.pctl_port];
				end
				MODE_DIR: begin
					pctl_rdata = dir_q[req.pctl_port];
				end
				default: begin
					pctl_rdata = ZERO_BYTE;
				end
			endcase
		end
	end

	// working register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			w_q <= ZERO_BYTE;
		end else if (x_cmp || x_pend || rd_cfg) begin
			w_q <= pctl_rdata;
		end else if (fwr && eff_addr == ADDR_COUNTER && !option_q[OPT_MAP]) begin
			w_q <= req.file_wdata;
		end else if (req.w_wr) begin
			w_q <= req.w_wdata;
		end
	end

	// per-port data latches and control registers
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic sel;
			assign sel = port_ok && (req.pctl_port == 3'(p)) && mwr;
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					port_data_q[p] <= ZERO_BYTE;
				end else if (fwr && eff_addr == ADDR_PORT_A + 5'(p)) begin
					port_data_q[p] <= req.file_wdata;
				end
			end
			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					dir_q[p]       <= PCTL_RESET;
					pullup_q[p]    <= PCTL_RESET;
					level_q[p]     <= PCTL_RESET;
					hysteresis_q[p] <= PCTL_RESET;
				end else if (sel) begin
					if (mlo == MODE_DIR) begin
						dir_q[p] <= w_q;
					end
					if (mlo == MODE_PULLUP) begin
						pullup_q[p] <= w_q;
					end
					if (mlo == MODE_LEVEL) begin
						level_q[p] <= w_q;
					end
					if (mlo == MODE_SCHMITT && p != 0) begin
						hysteresis_q[p] <= w_q;
					end
				end
			end
		end
	endgenerate

	// wakeup enable and edge, written whatever bit 4 holds
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wake_pin_enable_q  <= PCTL_RESET;
			wake_edge_select_q <= PCTL_RESET;
		end else begin
			if (wr_wen) begin
				wake_pin_enable_q <= w_q;
			end
			if (wr_wedge) begin
				wake_edge_select_q <= w_q;
			end
		end
	end

	// edge detect on port b, set wins over the exchange
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			wake_set[i] = (wake_edge_select_q[i] ?
				(prev_b_q[i] && !pin_in[PORT_B][i]) :
				(!prev_b_q[i] && pin_in[PORT_B][i])) &&
				!wake_pin_enable_q[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prev_b_q       <= ZERO_BYTE;
			wake_pending_q <= PEND_RESET;
			wake_event_q   <= 1'b0;
		end else begin
			prev_b_q     <= pin_in[PORT_B];
			wake_event_q <= |wake_set;
			if (x_pend) begin
				wake_pending_q <= w_q | wake_set;
			end else begin
				wake_pending_q <= wake_pending_q | wake_set;
			end
		end
	end

	// comparator control and live result in bit 0
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			comparator_reg_q <= PCTL_RESET;
		end else begin
			if (x_cmp) begin
				comparator_reg_q[7:1] <= w_q[7:1];
			end
			comparator_reg_q[CMP_RES] <= !comparator_reg_q[CMP_EN_N] &&
				cmp_gt;
		end
	end

	// alu with flag generation
	always_comb begin
		b_eff = (req.alu_op == ALU_SUB) ? ~req.alu_b : req.alu_b;
		if (req.alu_op == ALU_SUB) begin
			cin = carry_input_fuse ? 1'b1 : status_q[ST_C];
		end else begin
			cin = carry_input_fuse ? 1'b0 : status_q[ST_C];
		end
		sum9 = {1'b0, req.alu_a} + {1'b0, b_eff} + {8'h00, cin};
		nib5 = {1'b0, req.alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		alu_res   = req.alu_a;
		alu_cout  = status_q[ST_C];
		alu_dcout = status_q[ST_DC];
		case (req.alu_op)
			ALU_ADD, ALU_SUB: begin
				alu_res   = sum9[7:0];
				alu_cout  = sum9[8];
				alu_dcout = nib5[4];
			end
			ALU_RR: begin
				alu_res  = {status_q[ST_C], req.alu_a[7:1]};
				alu_cout = req.alu_a[0];
			end
			ALU_RL: begin
				alu_res  = {req.alu_a[6:0], status_q[ST_C]};
				alu_cout = req.alu_a[7];
			end
			default: begin
				alu_res = req.alu_a;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			alu_result_q <= ZERO_BYTE;
		end else if (req.alu_upd) begin
			alu_result_q <= alu_res;
		end
	end

	// status: page, alu flags; timeout and powerdown not writable
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			status_q <= STATUS_RESET;
		end else begin
			if (fwr && eff_addr == ADDR_STATUS) begin
				status_q[7:ST_PAGE_LSB] <= req.file_wdata[7:ST_PAGE_LSB];
			end
			if (req.alu_upd && req.alu_op != ALU_RR && req.alu_op != ALU_RL) begin
				status_q[ST_Z] <= (alu_res == ZERO_BYTE);
			end else if (fwr && eff_addr == ADDR_STATUS) begin
				status_q[ST_Z] <= req.file_wdata[ST_Z];
			end
			if (req.alu_upd) begin
				status_q[ST_DC] <= alu_dcout;
				status_q[ST_C]  <= alu_cout;
			end else if (fwr && eff_addr == ADDR_STATUS) begin
				status_q[ST_DC:ST_C] <= req.file_wdata[ST_DC:ST_C];
			end
			if (evt.wdt_timeout) begin
				status_q[ST_TO] <= 1'b0;
			end else if (evt.wdt_clear || evt.sleep) begin
				status_q[ST_TO] <= 1'b1;
			end
			if (evt.sleep) begin
				status_q[ST_PD] <= 1'b0;
			end else if (evt.wdt_clear) begin
				status_q[ST_PD] <= 1'b1;
			end
		end
	end

	// pc low byte and computed branch with page bits
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pc_low_q      <= ZERO_BYTE;
			branch_q      <= 1'b0;
			branch_addr_q <= 12'h000;
		end else begin
			branch_q <= fwr && eff_addr == ADDR_PC_LOW;
			if (fwr && eff_addr == ADDR_PC_LOW) begin
				pc_low_q      <= req.file_wdata;
				branch_addr_q <= {status_q[7:ST_PAGE_LSB], 1'b0,
					req.file_wdata};
			end else if (req.pc_load) begin
				pc_low_q <= req.pc_value;
			end
		end
	end

	// option register, loaded from w
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			option_q <= OPTION_RESET;
		end else if (req.opt_wr) begin
			option_q <= w_q;
		end
	end

	// counter source, prescaler and rollover
	assign src_tick = option_q[OPT_SRC] ?
		(option_q[OPT_EDGE] ? (prev_cpin_q && !counter_pin) :
		(!prev_cpin_q && counter_pin)) : evt.instr_tick;
	assign ps_tick = option_q[OPT_PSA] ? evt.wdt_tick : src_tick;
	assign shift   = {1'b0, option_q[2:0]} +
		{3'h0, !option_q[OPT_PSA]};
	assign mask9   = (9'h001 << shift) - 9'h001;
	assign ps_hit  = (ps_cnt_q & mask9[7:0]) == mask9[7:0];
	assign cnt_inc = option_q[OPT_PSA] ? src_tick : (src_tick && ps_hit);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prev_cpin_q <= 1'b0;
			ps_cnt_q    <= ZERO_BYTE;
		end else begin
			prev_cpin_q <= counter_pin;
			if (ps_tick) begin
				ps_cnt_q <= ps_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			counter_q      <= ZERO_BYTE;
			rollover_irq_q <= 1'b0;
			wdt_scaled_q   <= 1'b0;
		end else begin
			rollover_irq_q <= cnt_inc && counter_q == COUNTER_TOP &&
				!option_q[OPT_IRQ_N];
			wdt_scaled_q <= evt.wdt_tick &&
				(!option_q[OPT_PSA] || ps_hit);
			if (fwr && eff_addr == ADDR_COUNTER && option_q[OPT_MAP]) begin
				counter_q <= req.file_wdata;
			end else if (cnt_inc) begin
				counter_q <= counter_q + 8'h01;
			end
		end
	end

endmodule : cpr_bank

//--- core/cpr_pkg.sv
// constants, types and request carriers of the core register bank
// assumes one core clock and a core that issues at most one access a cycle
// How it works
// - schmitt enable bit 1 disables, resets 1
// - wake enable bit 0 enables, resets 1
// - wake edge bit 0 rising, 1 falling
// - pending flags exchange with working register
// - comparator register exchanges with working register
// - bit7 low enables, bit6 low drives pin (bit6 is only stored here, no pin output exists)
// - bit0 shows positive input above negative
// - port controls reset ffh, mode 1fh
// - address zero reads through file select
// - pc low byte exposed, page from status
// - status bits 7-5 select 512-word page
// - timeout flag set by clear/sleep, cleared timeout
// - powerdown flag set by clear, cleared sleep
// - alu sets zero, digit carry, carry
// - fuse low adds carry into add/sub
// - alu flags override a status write
// - option bit7 maps 01h, bit6 low enables irq
// - option bit5 source, bit4 edge select
// - option bit3 gives prescaler to watchdog
// - prescaler divides 2^(n+1) or 2^n
// - option register resets to all ones
// - mode selects register, bit4 write direction
// - mode value holds until rewritten
package cpr_pkg;
	localparam logic [4:0] ADDR_INDIRECT  = 5'h00;
	localparam logic [4:0] ADDR_COUNTER   = 5'h01;
	localparam logic [4:0] ADDR_PC_LOW    = 5'h02;
	localparam logic [4:0] ADDR_STATUS    = 5'h03;
	localparam logic [4:0] ADDR_FSEL      = 5'h04;
	localparam logic [4:0] ADDR_PORT_A    = 5'h05;
	localparam logic [4:0] ADDR_PORT_E    = 5'h09;
	localparam logic [4:0] ADDR_RAM_FIRST = 5'h0A;
	localparam logic [4:0] ADDR_RAM_LAST  = 5'h1F;
	localparam int         NUM_PORTS      = 5;
	localparam logic [2:0] PORT_A         = 3'h0;
	localparam logic [2:0] PORT_B         = 3'h1;
	localparam logic [2:0] PORT_E         = 3'h4;
	localparam logic [3:0] MODE_CMP       = 4'h8;
	localparam logic [3:0] MODE_PEND      = 4'h9;
	localparam logic [3:0] MODE_WEDGE     = 4'hA;
	localparam logic [3:0] MODE_WEN       = 4'hB;
	localparam logic [3:0] MODE_SCHMITT   = 4'hC;
	localparam logic [3:0] MODE_LEVEL     = 4'hD;
	localparam logic [3:0] MODE_PULLUP    = 4'hE;
	localparam logic [3:0] MODE_DIR       = 4'hF;
	localparam int         MODE_WRITE_BIT = 4;
	localparam logic [4:0] MODE_RESET     = 5'h1F;
	localparam logic [7:0] PCTL_RESET     = 8'hFF;
	localparam logic [7:0] OPTION_RESET   = 8'hFF;
	localparam logic [7:0] STATUS_RESET   = 8'h18;
	localparam logic [7:0] PEND_RESET     = 8'h00;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	localparam logic [7:0] COUNTER_TOP    = 8'hFF;
	localparam int         ST_PAGE_LSB    = 5;
	localparam int         ST_TO          = 4;
	localparam int         ST_PD          = 3;
	localparam int         ST_Z           = 2;
	localparam int         ST_DC          = 1;
	localparam int         ST_C           = 0;
	localparam int         OPT_MAP        = 7;
	localparam int         OPT_IRQ_N      = 6;
	localparam int         OPT_SRC        = 5;
	localparam int         OPT_EDGE       = 4;
	localparam int         OPT_PSA        = 3;
	localparam int         CMP_EN_N       = 7;
	localparam int         CMP_OUT_N      = 6;
	localparam int         CMP_RES        = 0;

	typedef enum logic [4:0] {
		ALU_MOV = 5'b00001,
		ALU_ADD = 5'b00010,
		ALU_SUB = 5'b00100,
		ALU_RR  = 5'b01000,
		ALU_RL  = 5'b10000
	} cpr_alu_op_t;

	typedef struct packed {
		logic        file_rd;
		logic        file_wr;
		logic [4:0]  file_addr;
		logic [7:0]  file_wdata;
		logic        w_wr;
		logic [7:0]  w_wdata;
		logic        pctl;
		logic [2:0]  pctl_port;
		logic        mode_wr;
		logic [4:0]  mode_wdata;
		logic        opt_wr;
		logic        alu_upd;
		cpr_alu_op_t alu_op;
		logic [7:0]  alu_a;
		logic [7:0]  alu_b;
		logic        pc_load;
		logic [7:0]  pc_value;
	} cpr_req_t;

	typedef struct packed {
		logic wdt_clear;
		logic sleep;
		logic wdt_timeout;
		logic instr_tick;
		logic wdt_tick;
	} cpr_evt_t;
endpackage : cpr_pkg

//--- test/cpr_bank_props.sv
// port assertions for the core register bank
// bound into every cpr_bank, single core clock domain
`timescale 1ns/1ps
module cpr_bank_props (
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire cpr_pkg::cpr_req_t req,
	input wire cpr_pkg::cpr_evt_t evt,
	input wire logic              cmp_gt,
	input wire logic [4:0]        mode_q,
	input wire logic [7:0]        w_q,
	input wire logic [7:0]        status_q,
	input wire logic [7:0]        option_q,
	input wire logic [7:0]        comparator_reg_q
);
	import cpr_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence cmp_on_s;
		(!comparator_reg_q[CMP_EN_N] && cmp_gt && !req.pctl) [*2];
	endsequence
	sequence cmp_off_s;
		(comparator_reg_q[CMP_EN_N] && !req.pctl) [*2];
	endsequence
	rst_vals_a: assert property (
		$rose(nrst) |-> mode_q == MODE_RESET && option_q == OPTION_RESET
		&& status_q == STATUS_RESET) else $error("reset values wrong");
	mode_hold_a: assert property (
		!req.mode_wr |=> $stable(mode_q)) else $error("mode changed");
	mode_load_a: assert property (
		req.mode_wr |=> mode_q == $past(req.mode_wdata))
		else $error("mode not loaded");
	opt_load_a: assert property (
		req.opt_wr |=> option_q == $past(w_q)) else $error("option load");
	tmo_clear_a: assert property (
		evt.wdt_timeout |=> !status_q[ST_TO]) else $error("timeout flag");
	sleep_flags_a: assert property (
		evt.sleep && !evt.wdt_timeout && !evt.wdt_clear
		|=> status_q[ST_TO:ST_PD] == 2'b10) else $error("sleep flags");
	ro_flags_a: assert property (
		evt == '0 |=> $stable(status_q[ST_TO:ST_PD]))
		else $error("read-only flags changed");
	cmp_result_a: assert property (
		cmp_on_s |=> comparator_reg_q[CMP_RES]) else $error("result low");
	cmp_off_a: assert property (
		cmp_off_s |=> !comparator_reg_q[CMP_RES]) else $error("result high");
endmodule : cpr_bank_props

bind cpr_bank cpr_bank_props u_props (.core_clk(core_clk), .nrst(nrst),
	.req(req), .evt(evt), .cmp_gt(cmp_gt), .mode_q(mode_q), .w_q(w_q),
	.status_q(status_q), .option_q(option_q),
	.comparator_reg_q(comparator_reg_q));

//--- test/cpr_bank_tb.sv
// self-checking bench for the core register bank
// inputs change on the falling edge of core_clk
`timescale 1ns/1ps
module cpr_bank_tb;
	import cpr_pkg::*;
	localparam int FW = 0, FR = 1, SW = 2, MW = 3, PX = 4, OW = 5;
	localparam int AD = 34, SB = 36, ROR = 40;
	logic            core_clk, nrst, cmp_gt, counter_pin, carry_input_fuse;
	cpr_req_t        req;
	cpr_evt_t        evt;
	logic [4:0][7:0] pin_in, dir_q, pullup_q, level_q, hys_q;
	logic [7:0]      rd_data_q, w_q, status_q, option_q, counter_q, alu_q;
	logic [7:0]      wen_q, wed_q, wpend_q, cmp_q, rd, pcl_q;
	logic [4:0]      mode_q;
	logic [11:0]     baddr_q;
	logic            rd_valid_q, irq_q, irq_seen, wdt_q, wdt_seen;
	int              mismatches, cmp_count, cycles;

	cpr_bank DUT (.core_clk(core_clk), .nrst(nrst), .req(req), .evt(evt),
		.pin_in(pin_in), .cmp_gt(cmp_gt), .counter_pin(counter_pin),
		.carry_input_fuse(carry_input_fuse), .rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q), .w_q(w_q), .mode_q(mode_q),
		.status_q(status_q), .option_q(option_q), .fsel_q(),
		.counter_q(counter_q), .pc_low_q(pcl_q), .branch_q(),
		.branch_addr_q(baddr_q), .alu_result_q(alu_q), .port_data_q(),
		.dir_q(dir_q), .pullup_q(pullup_q), .level_q(level_q),
		.hysteresis_q(hys_q), .wake_pin_enable_q(wen_q),
		.wake_edge_select_q(wed_q), .wake_pending_q(wpend_q),
		.wake_event_q(), .comparator_reg_q(cmp_q),
		.rollover_irq_q(irq_q), .wdt_scaled_q(wdt_q));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (irq_q === 1'b1)
			irq_seen <= 1'b1;
		if (wdt_q === 1'b1)
			wdt_seen <= 1'b1;
		if (cycles == 4000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic op(input cpr_req_t r, input cpr_evt_t e);
		req = r;
		evt = e;
		@(negedge core_clk);
		rd = rd_valid_q ? rd_data_q : 8'hXX;
		req = '0;
		evt = '0;
		@(negedge core_clk);
	endtask : op

	task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d);
		cpr_req_t r;
		r = '0;
		r.file_addr = a[4:0];
		r.file_wdata = d;
		r.w_wdata = d;
		r.mode_wdata = d[4:0];
		r.pctl_port = a[2:0];
		r.alu_a = a;
		r.alu_b = d;
		r.alu_op = cpr_alu_op_t'(k[4:0]);
		case (k)
			FW: r.file_wr = 1'b1;
			FR: r.file_rd = 1'b1;
			SW: r.w_wr = 1'b1;
			MW: r.mode_wr = 1'b1;
			PX: r.pctl = 1'b1;
			OW: r.opt_wr = 1'b1;
			default: r.alu_upd = 1'b1;
		endcase
		op(r, '0);
	endtask : acc

	function automatic logic [7:0] sel(input int m, input int p);
		case (m)
			12: return hys_q[p];
			13: return level_q[p];
			14: return pullup_q[p];
			default: return dir_q[p];
		endcase
	endfunction : sel

	task automatic t_rst();
		for (int m = 12; m < 16; m++)
			for (int p = 0; p < 5; p++)
				chk(sel(m, p), 8'hFF);
		chk(wen_q, 8'hFF);
		chk(wed_q, 8'hFF);
		chk({3'h0, mode_q}, 8'h1F);
		chk(option_q, 8'hFF);
		chk(cmp_q | 8'h01, 8'hFF);
	endtask : t_rst

	task automatic t_pctl();
		for (int m = 12; m < 16; m++) begin
			acc(MW, 8'h00, 8'(m + 16));
			for (int p = 0; p < 5; p++) begin
				acc(SW, 8'h00, 8'(m * 16 + p));
				acc(PX, 8'(p), 8'h00);
			end
			for (int p = 0; p < 5; p++)
				chk(sel(m, p), (m == 12 && p == 0) ? 8'hFF :
					8'(m * 16 + p));
			acc(MW, 8'h00, 8'(m));
			for (int p = 0; p < 5; p++) begin
				acc(PX, 8'(p), 8'h00);
				chk(w_q, (m == 12 && p == 0) ? 8'hFF :
					8'(m * 16 + p));
			end
		end
	endtask : t_pctl

	task automatic t_wake();
		acc(MW, 8'h00, 8'h1B);
		acc(SW, 8'h00, 8'hFE);
		acc(PX, 8'h01, 8'h00);
		chk(wen_q, 8'hFE);
		acc(MW, 8'h00, 8'h0A);
		acc(PX, 8'h01, 8'h00);
		chk(wed_q, 8'hFE);
		pin_in[1] = 8'h03;
		repeat (3) @(negedge core_clk);
		acc(FR, 8'h06, 8'h00);
		chk(rd, 8'h03);
		acc(MW, 8'h00, 8'h19);
		acc(SW, 8'h00, 8'h00);
		acc(PX, 8'h01, 8'h00);
		chk(w_q, 8'h01);
		chk(wpend_q, 8'h00);
	endtask : t_wake

	task automatic t_cmp();
		acc(MW, 8'h00, 8'h08);
		acc(PX, 8'h01, 8'h00);
		chk(w_q, 8'hFE);
		chk(cmp_q & 8'hFE, 8'h00);
		cmp_gt = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(cmp_q, 8'h01);
		acc(SW, 8'h00, 8'hFF);
		acc(PX, 8'h01, 8'h00);
		chk(w_q, 8'h01);
	endtask : t_cmp

	task automatic t_ind();
		acc(FW, 8'h04, 8'h0A);
		acc(FW, 8'h00, 8'h5A);
		acc(FR, 8'h0A, 8'h00);
		chk(rd, 8'h5A);
		acc(FR, 8'h00, 8'h00);
		chk(rd, 8'h5A);
		acc(FW, 8'h04, 8'h00);
		acc(FR, 8'h00, 8'h00);
		chk(rd, 8'h00);
	endtask : t_ind

	task automatic t_stat();
		acc(FW, 8'h03, 8'h00);
		chk(status_q, 8'h18);
		acc(FW, 8'h03, 8'h40);
		acc(FW, 8'h02, 8'h34);
		chk(baddr_q[11:4], 8'h43);
		chk(pcl_q, 8'h34);
		op('0, 5'h04);
		chk(status_q, 8'h48);
		op('0, 5'h10);
		chk(status_q, 8'h58);
		op('0, 5'h08);
		chk(status_q, 8'h50);
	endtask : t_stat

	task automatic t_alu();
		cpr_req_t r;
		r = '0;
		r.file_wr = 1'b1;
		r.file_addr = ADDR_STATUS;
		r.alu_upd = 1'b1;
		r.alu_op = ALU_ADD;
		r.alu_a = 8'hFF;
		r.alu_b = 8'h01;
		op(r, '0);
		chk(status_q, 8'h17);
		chk(alu_q, 8'h00);
		carry_input_fuse = 1'b0;
		acc(AD, 8'h01, 8'h01);
		chk(alu_q, 8'h03);
		carry_input_fuse = 1'b1;
		acc(SB, 8'h05, 8'h03);
		chk(status_q, 8'h13);
		acc(ROR, 8'h02, 8'h00);
		chk(status_q & 8'h01, 8'h00);
		chk(alu_q, 8'h81);
	endtask : t_alu

	task automatic t_opt();
		acc(SW, 8'h00, 8'h08);
		acc(OW, 8'h00, 8'h00);
		acc(FW, 8'h01, 8'h77);
		chk(w_q, 8'h77);
		acc(SW, 8'h00, 8'h88);
		acc(OW, 8'h00, 8'h00);
		acc(FW, 8'h01, 8'hFD);
		repeat (3) op('0, 5'h02);
		chk(counter_q, 8'h00);
		chk({7'h00, irq_seen}, 8'h01);
		acc(SW, 8'h00, 8'h80);
		acc(OW, 8'h00, 8'h00);
		repeat (4) op('0, 5'h02);
		chk(counter_q, 8'h02);
		acc(SW, 8'h00, 8'h82);
		acc(OW, 8'h00, 8'h00);
		repeat (8) op('0, 5'h02);
		acc(FR, 8'h01, 8'h00);
		chk(rd, 8'h03);
		acc(SW, 8'h00, 8'hB8);
		acc(OW, 8'h00, 8'h00);
		counter_pin = 1'b1;
		repeat (2) @(negedge core_clk);
		chk(counter_q, 8'h03);
		counter_pin = 1'b0;
		repeat (2) @(negedge core_clk);
		chk(counter_q, 8'h04);
		op('0, 5'h01);
		chk({7'h00, wdt_seen}, 8'h01);
	endtask : t_opt

	initial begin
		nrst = 1'b0;
		req = '0;
		evt = '0;
		pin_in = '0;
		cmp_gt = 1'b0;
		counter_pin = 1'b0;
		carry_input_fuse = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		cycles = 0;
		irq_seen = 1'b0;
		wdt_seen = 1'b0;
		repeat (5) @(negedge core_clk);
		nrst = 1'b1;
		t_rst();
		t_pctl();
		t_wake();
		t_cmp();
		t_ind();
		t_stat();
		t_alu();
		t_opt();
		give_verdict();
	end
endmodule : cpr_bank_tb
